// ### logic/mct_pkg.sv
`default_nettype none
package mct_pkg;
    localparam int CNT_W_DEF = 16;
    localparam int PSC_W     = 16;
    localparam int NCH       = 4;
    localparam int NPAIR     = 3;
    localparam int DT_W      = 8;
    localparam int CTRL_W    = 10;
    localparam int EV_W      = 6;
    localparam int CFG_W     = 4;

    // register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_PSC   = 8'h04;
    localparam logic [7:0] A_ARR   = 8'h08;
    localparam logic [7:0] A_CNT   = 8'h0c;
    localparam logic [7:0] A_STAT  = 8'h10;
    localparam logic [7:0] A_MASK  = 8'h14;
    localparam logic [7:0] A_DMAEN = 8'h18;
    localparam logic [7:0] A_CHCFG = 8'h1c;
    localparam logic [7:0] A_DT    = 8'h20;
    localparam logic [7:0] A_CCR0  = 8'h30;

    // event bit positions in status, mask and dma enable
    localparam int EV_UPD = 0;
    localparam int EV_CC0 = 1;
    localparam int EV_TRG = 5;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [PSC_W-1:0]  PSC_RST  = 16'h0000;
    localparam logic [31:0]       ARR_RST  = 32'h0000_ffff;
    localparam logic [DT_W-1:0]   DT_RST   = 8'h00;

    typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_CENTER, CNT_HOLD}
        mct_cnt_mode_t;
    typedef enum logic [1:0] {SRC_INT, SRC_ENC, SRC_TRIG, SRC_NONE}
        mct_clk_src_t;
    typedef enum logic [1:0] {CH_CAPTURE, CH_TOGGLE, CH_PWM, CH_LOW}
        mct_ch_mode_t;

    typedef struct packed {
        logic          hall_en;
        logic          moe;
        logic          trig_start;
        mct_clk_src_t  clk_src;
        logic          dbg_freeze;
        logic          one_pulse;
        mct_cnt_mode_t cnt_mode;
        logic          cen;
    } mct_ctrl_t;

    typedef struct packed {
        logic         comp_en;
        logic         cap_fall;
        mct_ch_mode_t mode;
    } mct_chcfg_t;
endpackage
`default_nettype wire

// ### logic/mct_channel.sv
`timescale 1ns/1ps
`default_nettype none
module mct_channel #(
    parameter int CNT_W = 16
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire mct_pkg::mct_chcfg_t cfg,
    input  wire logic                cap_in,
    input  wire logic                cap_force,
    input  wire logic [CNT_W-1:0]    cnt,
    input  wire logic                step,
    input  wire logic                wr,
    input  wire logic [CNT_W-1:0]    wdata,
    output logic      [CNT_W-1:0]    ccr_q,
    output logic                     ref_q,
    output logic                     event_q
);
    import mct_pkg::*;

    logic cap_pv_q;
    logic cap_edge;
    logic is_cap;
    logic match;

    assign cap_edge = cfg.cap_fall ? (cap_pv_q & ~cap_in)
                                   : (~cap_pv_q & cap_in);
    assign is_cap   = (cfg.mode == CH_CAPTURE);
    assign match    = step & (cnt == ccr_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_pv_q <= 1'b0;
        else
            cap_pv_q <= cap_in;
    end

    // a capture wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ccr_q <= '0;
        else if (is_cap && (cap_edge || cap_force))
            ccr_q <= cnt;
        else if (wr)
            ccr_q <= wdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            event_q <= 1'b0;
        else
            event_q <= is_cap ? (cap_edge | cap_force) : match;
    end

    // cnt < ccr gives 0% at ccr=0 and 100% once ccr exceeds the reload
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ref_q <= 1'b0;
        else
            case (cfg.mode)
                CH_TOGGLE: if (match) ref_q <= ~ref_q;
                CH_PWM:    ref_q <= (cnt < ccr_q);
                default:   ref_q <= 1'b0;
            endcase
    end
endmodule
`default_nettype wire

// ### logic/mct_deadtime.sv
`timescale 1ns/1ps
`default_nettype none
module mct_deadtime #(
    parameter int DT_W = 8
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            ref_in,
    input  wire logic [DT_W-1:0] dt,
    input  wire logic            comp_en,
    output logic                 out_p_q,
    output logic                 out_n_q
);
    logic            ref_pv_q;
    logic [DT_W-1:0] wait_q;

    // with comp_en set and dt nonzero, both legs stay low for dt+1 cycles after every reference edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_pv_q <= 1'b0;
            wait_q   <= '0;
            out_p_q  <= 1'b0;
            out_n_q  <= 1'b0;
        end
        else
        begin
            ref_pv_q <= ref_in;
            if (ref_in != ref_pv_q && comp_en && dt != '0)
            begin
                wait_q  <= dt;
                out_p_q <= 1'b0;
                out_n_q <= 1'b0;
            end
            else if (wait_q != '0)
                wait_q <= wait_q - 1'b1;
            else
            begin
                out_p_q <= ref_in;
                out_n_q <= ~ref_in & comp_en;
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/mct_timer.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mct_timer #(
    parameter bit ADVANCED = 1'b1,
    parameter int CNT_W    = mct_pkg::CNT_W_DEF
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output var  logic [31:0]                prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic [mct_pkg::NCH-1:0]    ch_in,
    input  wire logic                       trig_in,
    input  wire logic                       dbg_halt,
    output var  logic [mct_pkg::NCH-1:0]    ch_out,
    output var  logic [mct_pkg::NPAIR-1:0]  ch_out_n,
    output var  logic                       trig_out,
    output var  logic                       irq,
    output var  logic [mct_pkg::EV_W-1:0]   dma_req
);
    import mct_pkg::*;

    if (CNT_W < 2 || CNT_W > 16)
        $error("CNT_W must lie between 2 and 16");

    function automatic logic ccr_hit(input logic [7:0] a);
        ccr_hit = (a[7:4] == A_CCR0[7:4]) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [1:0] ccr_idx(input logic [7:0] a);
        ccr_idx = a[3:2];
    endfunction

    mct_ctrl_t                     ctrl_q;
    mct_chcfg_t [NCH-1:0]          chcfg_q;
    logic [PSC_W-1:0]              psc_q;
    logic [PSC_W-1:0]              pdiv_q;
    logic [CNT_W-1:0]              arr_q;
    logic [CNT_W-1:0]              cnt_q;
    logic [CNT_W-1:0]              cnt_d;
    logic                          down_q;
    logic                          down_d;
    logic                          step_q;
    logic [EV_W-1:0]               st_q;
    logic [EV_W-1:0]               mask_q;
    logic [EV_W-1:0]               dmaen_q;
    logic [EV_W-1:0]               ev;
    logic [DT_W-1:0]               dt_q;
    logic [NCH+1:0]                s1_q;
    logic [NCH+1:0]                s2_q;
    logic [NCH+1:0]                pv_q;
    logic [NCH-1:0]                cref;
    logic [NCH-1:0]                cc_ev;
    logic [NCH-1:0][CNT_W-1:0]     ccr;
    logic [NPAIR-1:0]              pp;
    logic [NPAIR-1:0]              pn;
    logic                          upd;
    logic                          tick;
    logic                          running;
    logic                          halted;
    logic                          trg_rise;
    logic                          hall_chg;
    logic                          enc_step;
    logic                          enc_up;
    logic                          oe;
    logic                          setup;
    logic                          wr;
    logic                          hit;
    logic [31:0]                   rd;

    // pins from outside the clock domain: two flops before any use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            pv_q <= '0;
        end
        else
        begin
            s1_q <= {dbg_halt, trig_in, ch_in};
            s2_q <= s1_q;
            pv_q <= s2_q;
        end
    end

    assign halted   = s2_q[NCH+1] & ctrl_q.dbg_freeze;
    assign running  = ctrl_q.cen & ~halted;
    assign trg_rise = s2_q[NCH] & ~pv_q[NCH];
    assign hall_chg = ctrl_q.hall_en & ((^s2_q[2:0]) != (^pv_q[2:0]));
    assign enc_step = (s2_q[0] ^ pv_q[0]) | (s2_q[1] ^ pv_q[1]);
    assign enc_up   = s2_q[0] ^ pv_q[1];
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pready & pwrite;

    always_comb
    begin
        case (ctrl_q.clk_src)
            SRC_INT:  tick = (pdiv_q == psc_q);
            SRC_ENC:  tick = enc_step;
            SRC_TRIG: tick = trg_rise;
            default:  tick = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pdiv_q <= '0;
        else if (!running || pdiv_q == psc_q)
            pdiv_q <= '0;
        else
            pdiv_q <= pdiv_q + 1'b1;
    end

    always_comb
    begin
        cnt_d  = cnt_q;
        down_d = down_q;
        upd    = 1'b0;
        if (running && tick)
        begin
            if (ctrl_q.clk_src == SRC_ENC)
            begin
                if (enc_up)
                begin
                    upd   = (cnt_q == arr_q);
                    cnt_d = upd ? '0 : cnt_q + 1'b1;
                end
                else
                begin
                    upd   = (cnt_q == '0);
                    cnt_d = upd ? arr_q : cnt_q - 1'b1;
                end
            end
            else
                case (ctrl_q.cnt_mode)
                    CNT_UP:
                    begin
                        upd   = (cnt_q >= arr_q);
                        cnt_d = upd ? '0 : cnt_q + 1'b1;
                    end
                    CNT_DOWN:
                    begin
                        upd   = (cnt_q == '0);
                        cnt_d = upd ? arr_q : cnt_q - 1'b1;
                    end
                    CNT_CENTER:
                    begin
                        if (!down_q && cnt_q >= arr_q)
                        begin
                            upd    = 1'b1;
                            down_d = 1'b1;
                            cnt_d  = (cnt_q == '0) ? '0 : cnt_q - 1'b1;
                        end
                        else if (down_q && cnt_q == '0)
                        begin
                            upd    = 1'b1;
                            down_d = 1'b0;
                            cnt_d  = (arr_q == '0) ? '0 : cnt_q + 1'b1;
                        end
                        else
                            cnt_d = down_q ? cnt_q - 1'b1
                                           : cnt_q + 1'b1;
                    end
                    default: cnt_d = cnt_q;
                endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= '0;
            down_q <= 1'b0;
            step_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= (wr && paddr == A_CNT) ? pwdata[CNT_W-1:0] : cnt_d;
            down_q <= down_d;
            step_q <= running & tick;
        end
    end

    // hardware clears cen at the next update event in one-pulse mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= mct_ctrl_t'(CTRL_RST);
        else if (wr && paddr == A_CTRL)
            ctrl_q <= mct_ctrl_t'(pwdata[CTRL_W-1:0]);
        else if (upd && ctrl_q.one_pulse)
            ctrl_q.cen <= 1'b0;
        else if (ctrl_q.trig_start && trg_rise)
            ctrl_q.cen <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            psc_q   <= PSC_RST;
            arr_q   <= ARR_RST[CNT_W-1:0];
            mask_q  <= '0;
            dmaen_q <= '0;
            chcfg_q <= '0;
            dt_q    <= DT_RST;
        end
        else if (wr)
            case (paddr)
                A_PSC:   psc_q   <= pwdata[PSC_W-1:0];
                A_ARR:   arr_q   <= pwdata[CNT_W-1:0];
                A_MASK:  mask_q  <= pwdata[EV_W-1:0];
                A_DMAEN: dmaen_q <= pwdata[EV_W-1:0];
                A_CHCFG: chcfg_q <= pwdata[NCH*CFG_W-1:0];
                A_DT:    dt_q    <= pwdata[DT_W-1:0];
                default: dt_q    <= dt_q;
            endcase
    end

    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        mct_channel #(.CNT_W(CNT_W)) u_ch (
            .pclk      (pclk),
            .presetn   (presetn),
            .cfg       (chcfg_q[i]),
            .cap_in    (s2_q[i]),
            .cap_force ((i == 0) && hall_chg),
            .cnt       (cnt_q),
            .step      (step_q),
            .wr        (wr && ccr_hit(paddr) && ccr_idx(paddr) == i),
            .wdata     (pwdata[CNT_W-1:0]),
            .ccr_q     (ccr[i]),
            .ref_q     (cref[i]),
            .event_q   (cc_ev[i])
        );
    end

    for (genvar i = 0; i < NPAIR; i++)
    begin : g_dt
        mct_deadtime #(.DT_W(DT_W)) u_dt (
            .pclk      (pclk),
            .presetn   (presetn),
            .ref_in    (cref[i]),
            .dt        (dt_q),
            .comp_en   (ADVANCED && chcfg_q[i].comp_en),
            .out_p_q   (pp[i]),
            .out_n_q   (pn[i])
        );
    end

    // a frozen advanced timer drops every leg to switch the drivers off
    assign oe = ADVANCED ? (ctrl_q.moe & ~halted) : 1'b1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch_out   <= '0;
            ch_out_n <= '0;
        end
        else
        begin
            ch_out   <= oe ? {cref[NCH-1], pp} : '0;
            ch_out_n <= oe ? pn : '0;
        end
    end

    assign ev = {trg_rise | hall_chg, cc_ev, upd};

    // a new event in the clearing cycle stays set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= '0;
        else if (wr && paddr == A_STAT)
            st_q <= (st_q & ~pwdata[EV_W-1:0]) | ev;
        else
            st_q <= st_q | ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq      <= 1'b0;
            dma_req  <= '0;
            trig_out <= 1'b0;
        end
        else
        begin
            irq      <= |(st_q & mask_q);
            dma_req  <= ev & dmaen_q;
            trig_out <= upd;
        end
    end

    always_comb
    begin
        rd  = '0;
        hit = 1'b1;
        case (paddr)
            A_CTRL:  rd[CTRL_W-1:0]    = ctrl_q;
            A_PSC:   rd[PSC_W-1:0]     = psc_q;
            A_ARR:   rd[CNT_W-1:0]     = arr_q;
            A_CNT:   rd[CNT_W-1:0]     = cnt_q;
            A_STAT:  rd[EV_W-1:0]      = st_q;
            A_MASK:  rd[EV_W-1:0]      = mask_q;
            A_DMAEN: rd[EV_W-1:0]      = dmaen_q;
            A_CHCFG: rd[NCH*CFG_W-1:0] = chcfg_q;
            A_DT:    rd[DT_W-1:0]      = dt_q;
            default:
            begin
                if (ccr_hit(paddr))
                    rd[CNT_W-1:0] = ccr[ccr_idx(paddr)];
                else
                    hit = 1'b0;
            end
        endcase
    end

    // zero wait states: pready rises for the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup && !pwrite)
                prdata <= rd;
        end
    end
endmodule
`default_nettype wire

// ### sim/mct_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mct_timer_chk (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic [mct_pkg::NCH-1:0]   ch_out,
    input wire logic [mct_pkg::NPAIR-1:0] ch_out_n,
    input wire logic                      irq
);
    import mct_pkg::*;
    wire setup = psel && !penable;
    wire bad   = paddr[1:0] != 2'b00;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RDY_NEXT:
        assert property (setup |=> pready) else $error("no ready after setup");
    AST_RDY_ONE:
        assert property (pready |=> !pready) else $error("ready too long");
    AST_RDY_CAUSE:
        assert property (pready |-> $past(setup)) else $error("stray ready");
    AST_ERR_WITH_RDY:
        assert property (pslverr |-> pready) else $error("error w/o ready");
    AST_ERR_MISALIGN:
        assert property (setup && bad |=> pslverr)
        else $error("misaligned not refused");
    AST_OK_MAPPED:
        assert property (setup && (paddr == A_CTRL || paddr == A_CCR0)
                         |=> !pslverr) else $error("mapped refused");
    AST_RD_HOLD:
        assert property (!(setup && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    AST_RD_ERR_ZERO:
        assert property (setup && !pwrite && bad |=> prdata == 32'h0)
        else $error("refused read not zero");
    AST_COMP_EXCL:
        assert property ((ch_out[2:0] & ch_out_n) == 3'h0)
        else $error("both legs high");
    AST_QUIET:
        assert property ($rose(presetn) |-> !irq && !pready
                         && ch_out == 4'h0 && ch_out_n == 3'h0)
        else $error("outputs busy at reset");

    cover property (setup && bad);
    cover property ($rose(ch_out[0]));
    cover property ($rose(irq));
endmodule
`default_nettype wire

// ### sim/mct_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module mct_drive_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       step,
    input  wire logic       dir,
    input  wire logic [1:0] cap,
    output var  logic [3:0] ch_in
);
    logic [1:0] ph_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_q <= 2'h0;
        end
        else if (step)
        begin
            ph_q <= dir ? ph_q - 2'h1 : ph_q + 2'h1;
        end
    end
    // gray order 00 10 11 01 going up, so a leads b; one pin per step
    assign ch_in = {cap, ph_q[1], ph_q[1] ^ ph_q[0]};
endmodule
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mct_pkg::*;
    typedef struct {logic [31:0] a; logic [31:0] b; int c; int d;} mct_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, sv;
    logic        trig_in, dbg_halt, trig_out, irq, step, dir, er;
    logic [1:0]  cap;
    logic [3:0]  ch_in, ch_out;
    logic [2:0]  ch_out_n;
    logic [5:0]  dma_req;
    int          err_total, samples_checked, np, nn, nt, nd, nq, n;
    // d holds the reload value of each counter row
    mct_row_t    cnt_rows[6] = '{'{1, 0, 10, 9}, '{1, 1, 5, 9},
        '{1, 4, 2, 9}, '{3, 0, 10, 9}, '{3, 9, 1, 9}, '{5, 0, 25, 4}};
    mct_row_t    pwm_rows[3] = '{'{0, 0, 0, 100}, '{10, 0, 100, 0},
        '{5, 2, 20, 20}};

    mct_timer u_mct_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in(ch_in),
        .trig_in(trig_in), .dbg_halt(dbg_halt), .ch_out(ch_out),
        .ch_out_n(ch_out_n), .trig_out(trig_out), .irq(irq),
        .dma_req(dma_req));
    mct_drive_model u_mct_drive_model (.pclk(pclk), .presetn(presetn),
        .step(step), .dir(dir), .cap(cap), .ch_in(ch_in));

    always #5 pclk = ~pclk;

    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // called just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic        w,
                       input logic [7:0]  a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n == 20)
        begin
            check("ready", 0, 1);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic window();
        np = 0;
        nn = 0;
        nt = 0;
        nd = 0;
        nq = 0;
        repeat (100)
        begin
            @(posedge pclk);
            np += ch_out[0];
            nn += ch_out_n[0];
            nt += trig_out;
            nd += (ch_out[2:0] != {3{ch_out[0]}});
            nq += dma_req[EV_UPD];
        end
    endtask

    task automatic pulse_pin(input int k);
        repeat (k)
        begin
            step <= 1'b1;
            @(posedge pclk);
            step <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, trig_in, dbg_halt} = 7'h0;
        {paddr, pwdata, step, dir, cap} = 44'h0;
        err_total = 0;
        samples_checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(A_DMAEN, 1);
        foreach (cnt_rows[i])
        begin
            wr(A_ARR, cnt_rows[i].d);
            wr(A_PSC, cnt_rows[i].b);
            wr(A_CNT, 0);
            wr(A_CTRL, cnt_rows[i].a);
            repeat (120) @(posedge pclk);
            window();
            check("updates", nt, cnt_rows[i].c);
            check("dma", nq, cnt_rows[i].c);
            wr(A_CTRL, 0);
        end
        $display("counter table done");
        wr(A_CTRL, 1);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (cnt_rows[i])
        begin
            rdr(A_CTRL + 8'(4 * i));
            check("reset val", rd, i == 2 ? ARR_RST : 32'h0);
        end
        wr(A_ARR, 32'h0001_2345);
        rdr(A_ARR);
        check("arr width", rd, 32'h0000_2345);
        wr(A_PSC, 32'hffff);
        rdr(A_PSC);
        check("psc max", rd, 32'hffff);
        rdr(8'h24);
        check("unmapped rd", rd, 32'h0);
        check("unmapped err", er, 1);
        apb(1'b1, 8'h02, 32'h5);
        check("misaligned", er, 1);
        $display("register test done");
        wr(A_PSC, 0);
        wr(A_ARR, 9);
        wr(A_MASK, 1);
        wr(A_CTRL, 1);
        n = 0;
        while (irq !== 1'b1 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        check("irq", irq, 1);
        wr(A_CTRL, 0);
        wr(A_STAT, 32'h3f);
        rdr(A_STAT);
        check("stat clear", rd, 0);
        check("irq low", irq, 0);
        wr(A_MASK, 0);
        wr(A_CTRL, 1);
        repeat (30) @(posedge pclk);
        check("masked", irq, 0);
        wr(A_CTRL, 0);
        rdr(A_STAT);
        check("sticky", rd[EV_UPD], 1);
        wr(A_CNT, 0);
        wr(A_CTRL, 32'h9);
        repeat (30) @(posedge pclk);
        rdr(A_CTRL);
        check("one pulse", rd, 32'h8);
        $display("interrupt test done");
        wr(A_CNT, 0);
        wr(A_CTRL, 32'h41);
        repeat (3)
        begin
            trig_in <= 1'b1;
            repeat (4) @(posedge pclk);
            trig_in <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        rdr(A_CNT);
        check("trig count", rd, 3);
        rdr(A_STAT);
        check("trig flag", rd[EV_TRG], 1);
        wr(A_ARR, 32'hffff);
        wr(A_CNT, 100);
        wr(A_CTRL, 32'h21);
        pulse_pin(8);
        rdr(A_CNT);
        check("enc up", rd, 108);
        dir <= 1'b1;
        pulse_pin(4);
        rdr(A_CNT);
        check("enc down", rd, 104);
        $display("trigger and encoder tests done");
        // hall input on with the counter stopped, so captures see a fixed count
        wr(A_CTRL, 32'h200);
        wr(A_CNT, 32'h1234);
        wr(A_CHCFG, 32'h400);
        wr(A_STAT, 32'h3f);
        cap <= 2'h1;
        repeat (6) @(posedge pclk);
        rdr(A_STAT);
        check("no rise cap", rd[EV_CC0+2], 0);
        check("hall flag", rd[EV_TRG], 1);
        check("hall cap", rd[EV_CC0], 1);
        cap <= 2'h0;
        repeat (6) @(posedge pclk);
        rdr(A_STAT);
        check("cap flag", rd[EV_CC0+2], 1);
        rdr(A_CCR0 + 8'h8);
        check("cap value", rd, 32'h1234);
        rdr(A_CCR0);
        check("hall value", rd, 32'h1234);
        $display("capture test done");
        wr(A_ARR, 9);
        wr(A_CHCFG, 32'haaa);
        wr(A_CTRL, 32'h101);
        foreach (pwm_rows[i])
        begin
            wr(A_DT, pwm_rows[i].b);
            for (int c = 0; c < 3; c++)
            begin
                wr(A_CCR0 + 8'(4 * c), pwm_rows[i].a);
            end
            repeat (40) @(posedge pclk);
            window();
            check("p leg", np, pwm_rows[i].c);
            check("n leg", nn, pwm_rows[i].d);
            check("phases", nd, 0);
        end
        $display("pwm test done");
        wr(A_CTRL, 32'h111);
        dbg_halt <= 1'b1;
        repeat (6) @(posedge pclk);
        check("halt out", {ch_out[2:0], ch_out_n}, 0);
        rdr(A_CNT);
        sv = rd;
        repeat (20) @(posedge pclk);
        rdr(A_CNT);
        check("halt cnt", rd, sv);
        dbg_halt <= 1'b0;
        repeat (40) @(posedge pclk);
        window();
        check("resume", np, 20);
        $display("debug test done");
        complete_run();
    end

    initial
    begin
        #300us;
        err_total++;
        complete_run();
    end
endmodule

bind mct_timer mct_timer_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_out(ch_out),
    .ch_out_n(ch_out_n), .irq(irq));
`default_nettype wire
